// *** src/pfmux_top.sv ***
// Pad function mux: APB registers, pad function selection and flexible pin routing
`timescale 1ns/100ps
`include "pfmux_cfg.svh"
module pfmux_top
  import pfmux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pad_zero_in,
  output logic pad_zero_out,
  output logic pad_zero_oe_n,
  input wire logic pad_one_in,
  output logic pad_one_out,
  output logic pad_one_oe_n,
  input wire logic pad_twelve_in,
  output logic pad_twelve_out,
  output logic pad_twelve_oe_n,
  input wire logic pad_thirteen_in,
  output logic pad_thirteen_out,
  output logic pad_thirteen_oe_n,
  input wire logic pad_fifteen_in,
  output logic pad_fifteen_out,
  output logic pad_fifteen_oe_n,
  input wire logic pad_sixteen_in,
  output logic pad_sixteen_out,
  output logic pad_sixteen_oe_n,
  input wire logic pad_twenty_two_in,
  output logic pad_twenty_two_out,
  output logic pad_twenty_two_oe_n,
  input wire logic pad_twenty_three_in,
  output logic pad_twenty_three_out,
  output logic pad_twenty_three_oe_n,
  output logic debug_clock,
  input wire logic debug_data_out,
  input wire logic debug_data_oe,
  output logic debug_data_in,
  input wire logic [23:0] general_out,
  input wire logic [23:0] general_oe,
  output logic [23:0] general_in,
  input wire logic bridge_serial_tx,
  output logic bridge_serial_rx,
  input wire logic [7:0] link_debug,
  input wire logic [11:0] radio_test_tx,
  input wire logic serial0_transmit,
  output logic serial0_receive,
  output logic serial0_clear_to_send,
  input wire logic serial0_request_to_send,
  input wire logic serial1_transmit,
  output logic serial1_receive,
  input wire logic twowire0_clock_out,
  input wire logic twowire0_clock_oe,
  output logic twowire0_clock_in,
  input wire logic twowire0_data_out,
  input wire logic twowire0_data_oe,
  output logic twowire0_data_in,
  input wire logic twowire1_clock_out,
  input wire logic twowire1_clock_oe,
  output logic twowire1_clock_in,
  input wire logic twowire1_data_out,
  input wire logic twowire1_data_oe,
  output logic twowire1_data_in,
  input wire logic pulse_channel_0,
  input wire logic pulse_channel_1,
  input wire logic pulse_channel_2,
  input wire logic pulse_channel_3,
  input wire logic pulse_channel_4
);

  // ****************************************
  // Constants and declarations
  // ****************************************
  localparam int PADS = `PFMUX_PAD_N;
  localparam int SN = `PFMUX_SHARED_N;
  localparam logic [PADS-1:0][4:0] PAD_NUM = `PFMUX_PAD_NUMS; // Pad number = general pin index
  localparam logic [PADS-1:0][4:0] FLEX_IDX = `PFMUX_FLEX_IDX; // Flexible index per pad
  localparam logic [PADS-1:0][3:0] RADIO_BIT = `PFMUX_RADIO_BIT; // Radio test bit per pad
  localparam logic [PADS-1:0] RADIO_PADS = `PFMUX_RADIO_PADS; // Pads offering function 4

  logic [31:0] func_a_reg, func_a_next; // Function enables
  logic [31:0] flex_en_reg, flex_en_next; // Flexible pin enables
  logic [2:0][31:0] sel_reg, sel_next; // Selector nibbles, index 0 at bit 0
  logic [31:0] prdata_reg, prdata_next; // Read data captured in setup
  logic [PADS-1:0] pad_raw; // Pad levels straight from the pins
  logic [PADS-1:0] sync1_reg, sync1_next; // First synchroniser stage
  logic [PADS-1:0] sync2_reg, sync2_next; // Second stage, safe to use
  logic [PADS-1:0] pad_out_reg, pad_out_next; // Pad output values
  logic [PADS-1:0] pad_oe_n_reg, pad_oe_n_next; // Pad enables, low drives
  pfmux_func_t [PADS-1:0] pad_func; // Function owning each pad
  logic [PADS-1:0] route_value; // Flexible router output value
  logic [PADS-1:0] route_drive; // Flexible router output enable
  logic [PADS-1:0][SN-1:0] route_capture; // Per-router input contribution
  logic [SN-1:0] shared_in_next, shared_in_reg; // Merged shared inputs
  logic [23:0] general_in_next, general_in_reg; // General pin inputs
  logic debug_clock_next, debug_clock_reg;
  logic debug_data_next, debug_data_reg;
  logic bridge_rx_next, bridge_rx_reg;
  logic addr_hit; // Address decodes to a register
  logic wr_fire; // Write accepted this edge

  pfmux_shared_if shared_bus ();

  // ****************************************
  // Pad vectors
  // ****************************************
  assign pad_raw = {pad_twenty_three_in, pad_twenty_two_in, pad_sixteen_in, pad_fifteen_in,
                    pad_thirteen_in, pad_twelve_in, pad_one_in, pad_zero_in};
  assign {pad_twenty_three_out, pad_twenty_two_out, pad_sixteen_out, pad_fifteen_out,
          pad_thirteen_out, pad_twelve_out, pad_one_out, pad_zero_out} = pad_out_reg;
  assign {pad_twenty_three_oe_n, pad_twenty_two_oe_n, pad_sixteen_oe_n, pad_fifteen_oe_n,
          pad_thirteen_oe_n, pad_twelve_oe_n, pad_one_oe_n, pad_zero_oe_n} = pad_oe_n_reg;

  // ****************************************
  // Shared signal table
  // ****************************************
  // Inputs-only indices carry no drive enable, so a pad selecting them never drives
  assign shared_bus.drive = {pulse_channel_4, pulse_channel_3, pulse_channel_2,
                             pulse_channel_1, pulse_channel_0, twowire1_data_out,
                             twowire1_clock_out, twowire0_data_out, twowire0_clock_out,
                             1'b0, serial1_transmit, serial0_request_to_send,
                             1'b0, 1'b0, serial0_transmit};
  assign shared_bus.drive_en = {5'h1F, twowire1_data_oe, twowire1_clock_oe, twowire0_data_oe,
                                twowire0_clock_oe, 6'h19};

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait state; a frozen clock enable stretches the access
  assign pready = pclk_en;
  assign wr_fire = psel && penable && pwrite && pclk_en && addr_hit;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;

  // Address decode
  always_comb
  begin
    case (paddr)
      `PFMUX_ADDR_FUNC_A, `PFMUX_ADDR_FLEX_EN, `PFMUX_ADDR_SEL0, `PFMUX_ADDR_SEL1,
      `PFMUX_ADDR_SEL2, `PFMUX_ADDR_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0; // Unmapped answers with an error
    endcase
  end

  // Byte-lane merge limited to the writable bits of a register
  function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old_val & ~lanes) | (new_val & lanes);
  endfunction

  // Register next values and read data
  always_comb
  begin
    func_a_next = func_a_reg;
    flex_en_next = flex_en_reg;
    sel_next = sel_reg;
    prdata_next = prdata_reg;
    if (wr_fire)
    begin
      case (paddr)
        `PFMUX_ADDR_FUNC_A: func_a_next = merge(func_a_reg, pwdata, pstrb, `PFMUX_FUNC_A_MASK);
        `PFMUX_ADDR_FLEX_EN: flex_en_next = merge(flex_en_reg, pwdata, pstrb,
                                                  `PFMUX_FLEX_EN_MASK);
        `PFMUX_ADDR_SEL0: sel_next[0] = merge(sel_reg[0], pwdata, pstrb, `PFMUX_SEL_MASK);
        `PFMUX_ADDR_SEL1: sel_next[1] = merge(sel_reg[1], pwdata, pstrb, `PFMUX_SEL_MASK);
        `PFMUX_ADDR_SEL2: sel_next[2] = merge(sel_reg[2], pwdata, pstrb, `PFMUX_SEL2_MASK);
        default: ; // Status is read-only
      endcase
    end
    // Read data is captured in the setup cycle so it leaves a flip-flop
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `PFMUX_ADDR_FUNC_A: prdata_next = func_a_reg;
        `PFMUX_ADDR_FLEX_EN: prdata_next = flex_en_reg;
        `PFMUX_ADDR_SEL0: prdata_next = sel_reg[0];
        `PFMUX_ADDR_SEL1: prdata_next = sel_reg[1];
        `PFMUX_ADDR_SEL2: prdata_next = sel_reg[2];
        `PFMUX_ADDR_STATUS: prdata_next = {16'h0000, ~pad_oe_n_reg, sync2_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_a_reg <= `PFMUX_FUNC_A_RST;
      flex_en_reg <= `PFMUX_FLEX_EN_RST;
      sel_reg <= {`PFMUX_SEL_RST & `PFMUX_SEL2_MASK, `PFMUX_SEL_RST, `PFMUX_SEL_RST};
      prdata_reg <= 32'h0000_0000;
    end
    else if (pclk_en)
    begin
      func_a_reg <= func_a_next;
      flex_en_reg <= flex_en_next;
      sel_reg <= sel_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************
  // Pad input synchroniser
  // ****************************************
  // Pads are asynchronous; only the second stage is read anywhere
  always_comb
  begin
    sync1_next = pad_raw;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else if (pclk_en)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ****************************************
  // Flexible pin routers
  // ****************************************
  // Pads 0 and 1 have no flexible function, so routers exist for pads 2 to 7 only
  genvar gi;
  generate
    for (gi = 0; gi < PADS; gi++)
    begin : g_route
      if (gi >= 2)
      begin : g_flex
        pfmux_flex_route u_route (
          .route_en (flex_en_reg[FLEX_IDX[gi]]),
          .route_sel (sel_reg[FLEX_IDX[gi] / 8][(FLEX_IDX[gi] % 8) * 4 +: 4]),
          .pad_level (sync2_reg[gi]),
          .shared (shared_bus.sink),
          .pad_value (route_value[gi]),
          .pad_drive (route_drive[gi]),
          .capture (route_capture[gi])
        );
      end
      else
      begin : g_none
        assign route_value[gi] = 1'b0;
        assign route_drive[gi] = 1'b0;
        assign route_capture[gi] = '1;
      end
    end
  endgenerate

  // ****************************************
  // Function selection
  // ****************************************
  // Enables are applied lowest function first so the highest one wins
  always_comb
  begin
    pad_func = '{default: PFMUX_FUNC_DEFAULT};
    if (func_a_reg[`PFMUX_PAD0_GEN_BIT])
      pad_func[0] = PFMUX_FUNC_GENERAL;
    if (func_a_reg[`PFMUX_PAD1_GEN_BIT])
      pad_func[1] = PFMUX_FUNC_GENERAL;
    if (func_a_reg[`PFMUX_PAD12_GEN_BIT])
      pad_func[2] = PFMUX_FUNC_GENERAL;
    if (func_a_reg[`PFMUX_PAD13_GEN_BIT])
      pad_func[3] = PFMUX_FUNC_GENERAL;
    if (func_a_reg[`PFMUX_LINK_DBG_LSB + `PFMUX_LINK_BIT_P12])
      pad_func[2] = PFMUX_FUNC_LINK_DEBUG;
    if (func_a_reg[`PFMUX_LINK_DBG_LSB + `PFMUX_LINK_BIT_P13])
      pad_func[3] = PFMUX_FUNC_LINK_DEBUG;
    for (int p = 2; p < PADS; p++)
    begin
      if (flex_en_reg[FLEX_IDX[p]])
        pad_func[p] = PFMUX_FUNC_FLEX;
      if (RADIO_PADS[p] && func_a_reg[`PFMUX_RADIO_EN_BIT])
        pad_func[p] = PFMUX_FUNC_RADIO;
    end
  end

  // ****************************************
  // Pad output mux
  // ****************************************
  // Debug clock and bridge receive pads are inputs in their default role
  always_comb
  begin
    pad_out_next = '0;
    pad_oe_n_next = '1;
    for (int p = 0; p < PADS; p++)
    begin
      case (pad_func[p])
        PFMUX_FUNC_DEFAULT:
        begin
          if (p == 1)
          begin
            pad_out_next[p] = debug_data_out;
            pad_oe_n_next[p] = !debug_data_oe;
          end
          else if (p == 2)
          begin
            pad_out_next[p] = bridge_serial_tx;
            pad_oe_n_next[p] = 1'b0;
          end
          else if (p >= 4)
          begin
            pad_out_next[p] = general_out[PAD_NUM[p]];
            pad_oe_n_next[p] = !general_oe[PAD_NUM[p]];
          end
        end
        PFMUX_FUNC_GENERAL:
        begin
          pad_out_next[p] = general_out[PAD_NUM[p]];
          pad_oe_n_next[p] = !general_oe[PAD_NUM[p]];
        end
        PFMUX_FUNC_LINK_DEBUG:
        begin
          // Output only
          pad_out_next[p] = link_debug[(p == 2) ? `PFMUX_LINK_BIT_P12 : `PFMUX_LINK_BIT_P13];
          pad_oe_n_next[p] = 1'b0;
        end
        PFMUX_FUNC_FLEX:
        begin
          pad_out_next[p] = route_value[p];
          pad_oe_n_next[p] = !route_drive[p];
        end
        PFMUX_FUNC_RADIO:
        begin
          pad_out_next[p] = radio_test_tx[RADIO_BIT[p]];
          pad_oe_n_next[p] = 1'b0;
        end
        default:
        begin
          pad_out_next[p] = 1'b0;
          pad_oe_n_next[p] = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Input return paths
  // ****************************************
  // A function that does not own its pad sees its idle level, never pad noise
  always_comb
  begin
    shared_in_next = '1;
    for (int p = 0; p < PADS; p++)
      shared_in_next &= (pad_func[p] == PFMUX_FUNC_FLEX) ? route_capture[p] : {SN{1'b1}};
    general_in_next = '0;
    for (int p = 0; p < PADS; p++)
    begin
      if (pad_func[p] == PFMUX_FUNC_GENERAL ||
          (p >= 4 && pad_func[p] == PFMUX_FUNC_DEFAULT))
        general_in_next[PAD_NUM[p]] = sync2_reg[p];
    end
    debug_clock_next = (pad_func[0] == PFMUX_FUNC_DEFAULT) && sync2_reg[0];
    debug_data_next = (pad_func[1] != PFMUX_FUNC_DEFAULT) || sync2_reg[1];
    bridge_rx_next = (pad_func[3] != PFMUX_FUNC_DEFAULT) || sync2_reg[3];
  end

  // Pad and return registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out_reg <= '0;
      pad_oe_n_reg <= '1;
      shared_in_reg <= '1;
      general_in_reg <= '0;
      debug_clock_reg <= 1'b0;
      debug_data_reg <= 1'b1;
      bridge_rx_reg <= 1'b1;
    end
    else if (pclk_en)
    begin
      pad_out_reg <= pad_out_next;
      pad_oe_n_reg <= pad_oe_n_next;
      shared_in_reg <= shared_in_next;
      general_in_reg <= general_in_next;
      debug_clock_reg <= debug_clock_next;
      debug_data_reg <= debug_data_next;
      bridge_rx_reg <= bridge_rx_next;
    end
  end

  // Shared inputs by index
  assign serial0_receive = shared_in_reg[1];
  assign serial0_clear_to_send = shared_in_reg[2];
  assign serial1_receive = shared_in_reg[5];
  assign twowire0_clock_in = shared_in_reg[6];
  assign twowire0_data_in = shared_in_reg[7];
  assign twowire1_clock_in = shared_in_reg[8];
  assign twowire1_data_in = shared_in_reg[9];
  assign general_in = general_in_reg;
  assign debug_clock = debug_clock_reg;
  assign debug_data_in = debug_data_reg;
  assign bridge_serial_rx = bridge_rx_reg;

endmodule

// *** src/pfmux_cfg.svh ***
// Register offsets, field positions, reset values and pad tables of the pad function mux
`ifndef PFMUX_CFG_SVH
`define PFMUX_CFG_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define PFMUX_ADDR_FUNC_A 32'h2013_2020
`define PFMUX_ADDR_FLEX_EN 32'h2013_2024
`define PFMUX_ADDR_SEL0 32'h2013_2028
`define PFMUX_ADDR_SEL1 32'h2013_202C
`define PFMUX_ADDR_SEL2 32'h2013_2030
`define PFMUX_ADDR_STATUS 32'h2013_2034

// ****************************************
// Field positions in pad_function_enable_a
// ****************************************
`define PFMUX_LINK_DBG_LSB 16
`define PFMUX_RADIO_EN_BIT 13
`define PFMUX_PAD13_GEN_BIT 12
`define PFMUX_PAD12_GEN_BIT 11
`define PFMUX_PAD1_GEN_BIT 10
`define PFMUX_PAD0_GEN_BIT 9

// ****************************************
// Writable masks and reset values
// ****************************************
`define PFMUX_FUNC_A_MASK 32'h00FF_3E00
`define PFMUX_FLEX_EN_MASK 32'h003F_FFFF
`define PFMUX_SEL_MASK 32'hFFFF_FFFF
`define PFMUX_SEL2_MASK 32'h00FF_FFFF
`define PFMUX_FUNC_A_RST 32'h0000_0000
`define PFMUX_FLEX_EN_RST 32'h0000_0000
`define PFMUX_SEL_RST 32'hFFFF_FFFF

// ****************************************
// Selector field and shared signal indices
// ****************************************
`define PFMUX_SEL_W 4
`define PFMUX_SEL_MAX 4'hE
`define PFMUX_SHARED_N 15
`define PFMUX_FLEX_N 22

// ****************************************
// Pad tables, pads packed as P0 P1 P12 P13 P15 P16 P22 P23
// ****************************************
`define PFMUX_PAD_N 8
`define PFMUX_PAD_NUMS {5'h17, 5'h16, 5'h10, 5'h0F, 5'h0D, 5'h0C, 5'h01, 5'h00}
`define PFMUX_FLEX_IDX {5'h15, 5'h14, 5'h0E, 5'h0D, 5'h0B, 5'h0A, 5'h00, 5'h00}
`define PFMUX_RADIO_BIT {4'h0, 4'hB, 4'h0, 4'h5, 4'h3, 4'h2, 4'h0, 4'h0}
`define PFMUX_RADIO_PADS 8'h5C
`define PFMUX_LINK_BIT_P12 5
`define PFMUX_LINK_BIT_P13 6

`endif

// *** src/pfmux_pkg.sv ***
// Types shared by the pad function mux modules
package pfmux_pkg;

  // One-hot code of the function that owns a pad
  typedef enum logic [4:0]
  {
    PFMUX_FUNC_DEFAULT = 5'h01,
    PFMUX_FUNC_GENERAL = 5'h02,
    PFMUX_FUNC_LINK_DEBUG = 5'h04,
    PFMUX_FUNC_FLEX = 5'h08,
    PFMUX_FUNC_RADIO = 5'h10
  } pfmux_func_t;

  // Shared-signal selector of one flexible pin
  typedef logic [3:0] pfmux_sel_t;

endpackage

// *** src/pfmux_shared_if.sv ***
// Bundle of shared peripheral drive values handed to the flexible pin routers
`timescale 1ns/100ps
interface pfmux_shared_if;
  logic [14:0] drive; // Output value per shared index
  logic [14:0] drive_en; // Active-high output enable per shared index

  // Top fills the bundle
  modport source (output drive, output drive_en);
  // Routers only read it
  modport sink (input drive, input drive_en);
endinterface

// *** src/pfmux_flex_route.sv ***
// One flexible shared pin: selector-driven routing of a shared signal to a pad
`timescale 1ns/100ps
`include "pfmux_cfg.svh"
module pfmux_flex_route
  import pfmux_pkg::*;
#(
  parameter int SHARED_N = `PFMUX_SHARED_N
)
(
  input wire logic route_en,
  input wire pfmux_sel_t route_sel,
  input wire logic pad_level,
  pfmux_shared_if.sink shared,
  output logic pad_value,
  output logic pad_drive,
  output logic [SHARED_N-1:0] capture
);

  // ****************************************
  // Routing
  // ****************************************
  // Unselected inputs read as idle high so that an AND across pins merges them
  always_comb
  begin
    pad_value = 1'b0;
    pad_drive = 1'b0;
    capture = '1;
    // Only codes 0 to 14 are shared signals; others leave the pad undriven
    if (route_en && (route_sel <= `PFMUX_SEL_MAX))
    begin
      pad_value = shared.drive[route_sel];
      pad_drive = shared.drive_en[route_sel];
      capture[route_sel] = pad_level;
    end
  end

endmodule

// *** test/pfmux_checker.sv ***
// Checker of pad twelve and pad zero ownership in the pad function mux
`timescale 1ns/100ps
`include "pfmux_cfg.svh"
module pfmux_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pad_zero_out,
  input wire logic pad_zero_oe_n,
  input wire logic pad_twelve_out,
  input wire logic pad_twelve_oe_n,
  input wire logic [23:0] general_out,
  input wire logic [23:0] general_oe,
  input wire logic bridge_serial_tx,
  input wire logic [7:0] link_debug,
  input wire logic [11:0] radio_test_tx,
  input wire logic serial0_transmit
);
  // ****************************************
  // Register shadows
  // ****************************************
  logic [31:0] fa, fe, s1; // Copies of enable and selector words
  logic wr, rd, fx, lk, gn, df; // Full-word write and who should own pad twelve
  logic [1:0] p12; // Pad twelve drive pair
  assign wr = psel && penable && pwrite && pready && pstrb == 4'hF;
  assign rd = fa[13];
  assign fx = fe[10] && !rd;
  assign lk = fa[21] && !rd && !fe[10];
  assign gn = fa[11] && !fa[21] && !rd && !fe[10];
  assign df = !(fa[11] || fa[21] || rd || fe[10]);
  assign p12 = {pad_twelve_oe_n, pad_twelve_out};
  // Partial strobes are never sent, so only whole words are tracked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fa <= 32'h0;
      fe <= 32'h0;
      s1 <= 32'hFFFF_FFFF;
    end
    else if (wr)
    begin
      case (paddr)
        `PFMUX_ADDR_FUNC_A: fa <= pwdata;
        `PFMUX_ADDR_FLEX_EN: fe <= pwdata;
        `PFMUX_ADDR_SEL1: s1 <= pwdata;
        default: ;
      endcase
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_pad0_gen;
    fa[9] |=> pad_zero_out == $past(general_out[0]) && pad_zero_oe_n == !$past(general_oe[0]);
  endproperty
  a_pad0_gen: assert property (p_pad0_gen) else $error("pad zero not general");
  property p_pad0_dflt;
    !fa[9] |=> pad_zero_oe_n;
  endproperty
  a_pad0_dflt: assert property (p_pad0_dflt) else $error("pad zero driven");
  property p_radio;
    rd |=> p12 == {1'b0, $past(radio_test_tx[2])};
  endproperty
  a_radio: assert property (p_radio) else $error("pad twelve not radio");
  property p_link;
    lk |=> p12 == {1'b0, $past(link_debug[5])};
  endproperty
  a_link: assert property (p_link) else $error("pad twelve not link");
  property p_flex;
    fx && s1[11:8] == 4'h0 |=> p12 == {1'b0, $past(serial0_transmit)};
  endproperty
  a_flex: assert property (p_flex) else $error("pad twelve not flex");
  property p_flex_off;
    fx && s1[11:8] == 4'hF |=> pad_twelve_oe_n;
  endproperty
  a_flex_off: assert property (p_flex_off) else $error("pad twelve driven");
  property p_gen;
    gn |=> pad_twelve_oe_n == !$past(general_oe[12]);
  endproperty
  a_gen: assert property (p_gen) else $error("pad twelve not general");
  property p_dflt;
    df && $past(presetn) |=> p12 == {1'b0, $past(bridge_serial_tx)};
  endproperty
  a_dflt: assert property (p_dflt) else $error("pad twelve not bridge");
endmodule

bind pfmux_top pfmux_checker chk_u (.*);

// *** test/pfmux_pad_model.sv ***
// Pad ring model for the pad function mux
`timescale 1ns/100ps
module pfmux_pad_model
(
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] ext,
  output logic [7:0] lvl
);
  // A driven pad shows the mux value; a released one shows the board level
  assign lvl = (~oe_n & out) | (oe_n & ext);
endmodule

// *** test/test_pad_function_mux.sv ***
// Random testbench of the pad function mux
`timescale 1ns/100ps
`include "pfmux_cfg.svh"
module test_pad_function_mux;
  import pfmux_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hF; // Whole words only
  logic pready, pslverr, e, debug_clock, debug_data_in, bridge_serial_rx;
  logic [23:0] general_out = 0, general_oe = 0, general_in;
  logic [7:0] link_debug = 0, pe = 0, lv; // Board levels and pad levels
  logic [11:0] radio_test_tx = 0;
  logic serial0_receive, serial0_clear_to_send, serial1_receive;
  logic twowire0_clock_in, twowire0_data_in, twowire1_clock_in, twowire1_data_in;
  logic bridge_serial_tx = 0, debug_data_out = 0, debug_data_oe = 0;
  logic serial0_transmit = 0, serial0_request_to_send = 0, serial1_transmit = 0;
  logic twowire0_clock_out = 0, twowire0_clock_oe = 0, twowire0_data_out = 0;
  logic twowire0_data_oe = 0, twowire1_clock_out = 0, twowire1_clock_oe = 0;
  logic twowire1_data_out = 0, twowire1_data_oe = 0;
  logic pulse_channel_0 = 0, pulse_channel_1 = 0, pulse_channel_2 = 0;
  logic pulse_channel_3 = 0, pulse_channel_4 = 0;
  logic [7:0] po, pn; // Pad values and enables
  wire pad_zero_in, pad_one_in, pad_twelve_in, pad_thirteen_in;
  wire pad_fifteen_in, pad_sixteen_in, pad_twenty_two_in, pad_twenty_three_in;
  logic pad_zero_out, pad_one_out, pad_twelve_out, pad_thirteen_out;
  logic pad_fifteen_out, pad_sixteen_out, pad_twenty_two_out, pad_twenty_three_out;
  logic pad_zero_oe_n, pad_one_oe_n, pad_twelve_oe_n, pad_thirteen_oe_n;
  logic pad_fifteen_oe_n, pad_sixteen_oe_n, pad_twenty_two_oe_n, pad_twenty_three_oe_n;
  logic [14:0] sd, se; // Shared drive values and enables by index
  logic [31:0] q, a, f, s; // Read data and chosen register words
  int err_total = 0, check_count = 0;
  assign po = {pad_twenty_three_out, pad_twenty_two_out, pad_sixteen_out, pad_fifteen_out,
    pad_thirteen_out, pad_twelve_out, pad_one_out, pad_zero_out};
  assign pn = {pad_twenty_three_oe_n, pad_twenty_two_oe_n, pad_sixteen_oe_n, pad_fifteen_oe_n,
    pad_thirteen_oe_n, pad_twelve_oe_n, pad_one_oe_n, pad_zero_oe_n};
  assign {pad_twenty_three_in, pad_twenty_two_in, pad_sixteen_in, pad_fifteen_in,
    pad_thirteen_in, pad_twelve_in, pad_one_in, pad_zero_in} = lv;
  assign sd = {pulse_channel_4, pulse_channel_3, pulse_channel_2, pulse_channel_1,
    pulse_channel_0, twowire1_data_out, twowire1_clock_out, twowire0_data_out,
    twowire0_clock_out, 1'b0, serial1_transmit, serial0_request_to_send, 2'b00,
    serial0_transmit};
  assign se = {5'h1F, twowire1_data_oe, twowire1_clock_oe, twowire0_data_oe,
    twowire0_clock_oe, 1'b0, 2'b11, 2'b00, 1'b1};
  always #12.5 pclk = ~pclk;
  pfmux_top dut_u (.*);
  pfmux_pad_model pad_u (.out(po), .oe_n(pn), .ext(pe), .lvl(lv));
  // ****************************************
  // Tasks and expectations
  // ****************************************
  // One APB transfer; waits on pready, the watchdog ends a hang
  task automatic apb(input logic w, input logic [31:0] ad, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Released pads compare on the enable alone
  function automatic logic [1:0] nm(input logic [1:0] v);
    return v[1] ? 2'b10 : v;
  endfunction
  // Pad twelve owner by priority radio, flexible, link, general, default
  function automatic logic [1:0] exp12();
    logic [3:0] k;
    k = s[11:8];
    if (a[13])
      return {1'b0, radio_test_tx[2]};
    if (f[10])
      return (k != 4'hF && se[k]) ? {1'b0, sd[k]} : 2'b10;
    if (a[21])
      return {1'b0, link_debug[5]};
    if (a[11])
      return {!general_oe[12], general_out[12]};
    return {1'b0, bridge_serial_tx};
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(28503));
    apb(0, `PFMUX_ADDR_FUNC_A, 0);
    chk(q, 32'h0);
    apb(0, `PFMUX_ADDR_SEL1, 0);
    chk(q, 32'hFFFF_FFFF);
    apb(0, 32'h2013_2040, 0);
    chk(q, 32'h0);
    chk(e, 1'b1);
    // Selector code walks through every value while enables stay sparse
    for (int i = 0; i < 64; i++)
    begin
      @(posedge pclk);
      {pulse_channel_4, pulse_channel_3, pulse_channel_2, pulse_channel_1, pulse_channel_0,
        twowire1_data_out, twowire1_clock_out, twowire0_data_out, twowire0_clock_out,
        twowire1_data_oe, twowire1_clock_oe, twowire0_data_oe, twowire0_clock_oe,
        serial1_transmit, serial0_request_to_send, serial0_transmit,
        bridge_serial_tx, debug_data_out, debug_data_oe} <= 19'($urandom);
      general_out <= 24'($urandom);
      general_oe <= 24'($urandom);
      link_debug <= 8'($urandom);
      radio_test_tx <= 12'($urandom);
      pe <= 8'($urandom);
      a = $urandom & $urandom & $urandom;
      f = $urandom & $urandom;
      s = {$urandom} & 32'hFFFF_F0FF | {20'h0, 4'(i), 8'h0};
      apb(1, `PFMUX_ADDR_FUNC_A, a);
      apb(1, `PFMUX_ADDR_FLEX_EN, f);
      apb(1, `PFMUX_ADDR_SEL1, s);
      apb(0, `PFMUX_ADDR_FUNC_A, 0);
      chk(q, a & `PFMUX_FUNC_A_MASK);
      apb(0, `PFMUX_ADDR_FLEX_EN, 0);
      chk(q, f & `PFMUX_FLEX_EN_MASK);
      repeat (4) @(posedge pclk);
      #1;
      chk(nm({pad_twelve_oe_n, pad_twelve_out}), nm(exp12()));
      chk(debug_clock, a[9] ? 1'b0 : pe[0]);
      chk(bridge_serial_rx, (a[12] | a[22] | a[13] | f[11]) ? 1'b1 : pe[3]);
    end
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 1300 cycles
  initial
  begin
    #(25 * 20000);
    err_total++;
    report_and_stop();
  end
endmodule
